// >>> src/mch_top.sv
// Module clock halt block: two software halt registers on APB; the first
// drives per-peripheral clock enables and standby flags.
// Assumes one system clock and a 32-bit APB master.
//
// Chosen here: the APB register port and the address map.
module mch_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             serial_comm_unit_clk_en_o,
    output logic             general_timer_clk_en_o,
    output logic             flash_clk_en_o,
    output logic             serial_comm_unit_standby_o,
    output logic             general_timer_standby_o,
    output logic             flash_standby_o
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic access;
    logic hit1;
    logic hit2;
    logic hit_st;
    logic mapped;

    assign access = psel_i & penable_i;
    assign hit1   = (paddr_i == mch_pkg::MCH_HALT1_OFFSET);
    assign hit2   = (paddr_i == mch_pkg::MCH_HALT2_OFFSET);
    assign hit_st = (paddr_i == mch_pkg::MCH_STATUS_OFFSET);
    assign mapped = hit1 | hit2 | hit_st;

    // ------------------------------------------------------------------
    // Halt registers
    // ------------------------------------------------------------------
    logic [7:0] halt1;
    logic [7:0] halt2;

    // Writes of 0 halt a module; writes of 1 release it again.
    mch_halt_reg #(
        .RESET_VAL (mch_pkg::MCH_HALT1_RESET),
        .WR_MASK   (mch_pkg::MCH_HALT1_MASK)
    ) u_halt1 (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wr_i     (access & pwrite_i & hit1),
        .wdata_i  (pwdata_i[7:0]),
        .value_o  (halt1)
    );

    mch_halt_reg #(
        .RESET_VAL (mch_pkg::MCH_HALT2_RESET),
        .WR_MASK   (mch_pkg::MCH_HALT2_MASK)
    ) u_halt2 (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wr_i     (access & pwrite_i & hit2),
        .wdata_i  (pwdata_i[7:0]),
        .value_o  (halt2)
    );

    // ------------------------------------------------------------------
    // Clock enables and standby flags
    // ------------------------------------------------------------------
    logic [2:0] run;
    logic [2:0] en_r;
    logic [2:0] sb_r;

    always_comb begin
        run[0] = halt1[mch_pkg::MCH_SERIAL_BIT];
        run[1] = halt1[mch_pkg::MCH_TIMER_BIT];
        run[2] = halt1[mch_pkg::MCH_FLASH_BIT];
    end

    mch_clock_gate #(
        .STAGES (mch_pkg::MCH_GATE_STAGES)
    ) u_gate_serial (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (run[0]),
        .clk_en_o  (en_r[0]),
        .standby_o (sb_r[0])
    );

    mch_clock_gate #(
        .STAGES (mch_pkg::MCH_GATE_STAGES)
    ) u_gate_timer (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (run[1]),
        .clk_en_o  (en_r[1]),
        .standby_o (sb_r[1])
    );

    mch_clock_gate #(
        .STAGES (mch_pkg::MCH_GATE_STAGES)
    ) u_gate_flash (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (run[2]),
        .clk_en_o  (en_r[2]),
        .standby_o (sb_r[2])
    );

    assign serial_comm_unit_clk_en_o  = en_r[0];
    assign general_timer_clk_en_o     = en_r[1];
    assign flash_clk_en_o             = en_r[2];
    assign serial_comm_unit_standby_o = sb_r[0];
    assign general_timer_standby_o    = sb_r[1];
    assign flash_standby_o            = sb_r[2];

    // ------------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------------
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic        ready_nxt;
    logic        ready_r;
    logic        err_nxt;
    logic        err_r;

    // A one-wait-state answer: pready rises in the first access cycle's
    // following edge, so every transfer takes setup plus two access cycles.
    always_comb begin
        ready_nxt = access & ~ready_r;
        err_nxt   = access & ~ready_r & ~mapped;
        rdata_nxt = 32'h0000_0000;
        if (access & ~ready_r & ~pwrite_i) begin
            if (hit1) begin
                rdata_nxt = {24'h00_0000, halt1};
            end else if (hit2) begin
                rdata_nxt = {24'h00_0000, halt2};
            end else if (hit_st) begin
                rdata_nxt = {29'h0000_0000, sb_r};
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
            ready_r <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r   <= err_nxt;
        end
    end

    assign prdata_o  = rdata_r;
    assign pready_o  = ready_r;
    assign pslverr_o = err_r;

endmodule // mch_top

// >>> src/mch_pkg.sv
// Constants for the module clock halt block: register map, bit positions,
// reset values, writable masks and clock enable register depth.
// Assumes a 32-bit APB master and one 20 MHz system clock.
package mch_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] MCH_HALT1_OFFSET = 12'h000;
    localparam logic [11:0] MCH_HALT2_OFFSET = 12'h004;
    localparam logic [11:0] MCH_STATUS_OFFSET = 12'h008;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MCH_FLASH_BIT   = 1;
    localparam int MCH_TIMER_BIT   = 2;
    localparam int MCH_RSVD_BIT    = 3;
    localparam int MCH_SERIAL_BIT  = 7;
    localparam int MCH_REG_WIDTH   = 8;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] MCH_HALT1_RESET = 8'h8E;
    localparam logic [7:0] MCH_HALT1_MASK  = 8'h8E;
    localparam logic [7:0] MCH_HALT2_RESET = 8'hFF;
    localparam logic [7:0] MCH_HALT2_MASK  = 8'hFF;

    // ------------------------------------------------------------------
    // Clock enable register depth
    // ------------------------------------------------------------------
    localparam int MCH_GATE_STAGES = 1;

endpackage : mch_pkg

// >>> src/mch_clock_gate.sv
// One clock gate for a peripheral: a registered clock enable and standby flag.
// Assumes the run request changes synchronously to clk_i; the peripheral
// uses the enable as a clock enable qualifier rather than a gated clock.
module mch_clock_gate #(
    parameter int STAGES = 2
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic run_i,
    output logic      clk_en_o,
    output logic      standby_o
);

    initial begin
        if (STAGES < 1) begin
            $error("mch_clock_gate: STAGES must be at least 1");
        end
    end

    logic [STAGES-1:0] pipe_r;
    logic [STAGES-1:0] pipe_nxt;
    logic              standby_r;
    logic              standby_nxt;

    always_comb begin
        pipe_nxt    = STAGES'({pipe_r, run_i});
        standby_nxt = ~pipe_nxt[STAGES-1];
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pipe_r    <= '1;
            standby_r <= 1'b0;
        end else begin
            pipe_r    <= pipe_nxt;
            standby_r <= standby_nxt;
        end
    end

    assign clk_en_o  = pipe_r[STAGES-1];
    assign standby_o = standby_r;

endmodule // mch_clock_gate

// >>> src/mch_halt_reg.sv
// One eight-bit clock halt register with a writable mask.
// Assumes writes are qualified by the APB access phase in the parent.
module mch_halt_reg #(
    parameter logic [7:0] RESET_VAL = 8'hFF,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] value_o
);

    logic [7:0] value_r;
    logic [7:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (wr_i) begin
            value_nxt = (wdata_i & WR_MASK) | (RESET_VAL & ~WR_MASK);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            value_r <= RESET_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value_o = value_r;

endmodule // mch_halt_reg

// >>> sim/mch_top_props.sv
// Checker for mch_top: clock enables and standby flags against halt writes.
// Assumes the one-wait-state APB answer of mch_top.
module mch_top_props (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pslverr_o,
    input wire logic        serial_comm_unit_clk_en_o,
    input wire logic        general_timer_clk_en_o,
    input wire logic        flash_clk_en_o,
    input wire logic        serial_comm_unit_standby_o,
    input wire logic        general_timer_standby_o,
    input wire logic        flash_standby_o,
    input wire logic        pready_o
);
    logic       wr0;
    logic [2:0] en;
    logic [2:0] sb;
    assign wr0 = psel_i && penable_i && pwrite_i && !pready_o
               && paddr_i == mch_pkg::MCH_HALT1_OFFSET;
    assign en = {serial_comm_unit_clk_en_o, general_timer_clk_en_o, flash_clk_en_o};
    assign sb = {serial_comm_unit_standby_o, general_timer_standby_o, flash_standby_o};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_serial_follows: assert property (
        wr0 |-> ##2 serial_comm_unit_clk_en_o == $past(pwdata_i[7], 2)) else $error("serial");
    a_timer_follows: assert property (
        wr0 |-> ##2 general_timer_clk_en_o == $past(pwdata_i[2], 2)) else $error("timer");
    a_flash_follows: assert property (
        wr0 |-> ##2 flash_clk_en_o == $past(pwdata_i[1], 2)) else $error("flash");
    a_standby_inverse: assert property (sb == ~en) else $error("standby");
    a_enables_hold: assert property ($changed(en) |-> $past(wr0, 2)) else $error("hold");
    a_reset_clocked: assert property ($rose(resetn_i) |-> en == 3'h7) else $error("rst");
    a_release_on_one: assert property (
        wr0 && pwdata_i[7] && pwdata_i[2] && pwdata_i[1] |-> ##2 en == 3'h7) else $error("rel");
    c_clear_all: cover property (wr0 && pwdata_i[7:0] == 8'h08);
    c_restore: cover property (wr0 && pwdata_i[7:0] == 8'h8E);
    c_unmapped: cover property (pslverr_o);
endmodule // mch_top_props

bind mch_top mch_top_props u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o),
    .serial_comm_unit_clk_en_o(serial_comm_unit_clk_en_o),
    .general_timer_clk_en_o(general_timer_clk_en_o), .flash_clk_en_o(flash_clk_en_o),
    .serial_comm_unit_standby_o(serial_comm_unit_standby_o),
    .general_timer_standby_o(general_timer_standby_o),
    .flash_standby_o(flash_standby_o), .pready_o(pready_o)
);

// >>> sim/tb_mch_top.sv
// Self-checking bench for mch_top: halt registers over APB and clock outputs.
// Assumes the one-wait-state APB slave and a 50 ns system clock.
module tb_mch_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [2:0]  en, sb;
    int          err_count, tests_run;
    logic [7:0]  halt_wr [3] = '{8'h0E, 8'h8A, 8'h8C};
    logic [2:0]  exp_en  [3] = '{3'h3, 3'h5, 3'h6};
    mch_top dut (
        .clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .serial_comm_unit_clk_en_o(en[2]), .general_timer_clk_en_o(en[1]),
        .flash_clk_en_o(en[0]), .serial_comm_unit_standby_o(sb[2]),
        .general_timer_standby_o(sb[1]), .flash_standby_o(sb[0])
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer; holds the request until pready is sampled high.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        serr = pslverr;
        if (n >= 20) begin
            err_count++;
            print_verdict();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check(32'(en), 32'h7);
        check(32'(en ^ sb), 32'h7);
        xfer(1'b0, 12'h000, 32'h0);
        check(rdata, 32'h0000008E);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 12'h000, {24'h0, halt_wr[i]});
            check(32'(en), 32'(exp_en[i]));
            check(32'(en ^ sb), 32'h7);
            xfer(1'b1, 12'h000, 32'h0000008E);
            check(32'(en), 32'h7);
        end
        xfer(1'b1, 12'h000, 32'h00000086);
        check(32'(en), 32'h7);
        xfer(1'b0, 12'h000, 32'h0);
        check(rdata, 32'h00000086);
        xfer(1'b1, 12'h000, 32'h00000008);
        check(32'(sb), 32'h7);
        xfer(1'b0, 12'h000, 32'h0);
        check(rdata, 32'h00000008);
        xfer(1'b0, 12'h008, 32'h0);
        check(rdata, 32'h00000007);
        xfer(1'b1, 12'h000, 32'h0000008E);
        check(32'(en), 32'h7);
        xfer(1'b0, 12'h008, 32'h0);
        check(rdata, 32'h00000000);
        xfer(1'b1, 12'h004, 32'h0000005A);
        xfer(1'b0, 12'h004, 32'h0);
        check(rdata, 32'h0000005A);
        check(32'(en), 32'h7);
        xfer(1'b0, 12'h00C, 32'h0);
        check(32'(serr), 32'h1);
        check(rdata, 32'h0);
        print_verdict();
    end
endmodule // tb_mch_top
